/* rtl/mdec_core.sv */
// decode and execution of multiply, control and i/o instructions
`default_nettype none
module mdec_core
	import mdec_pkg::*;
#(
	parameter int WORD = mdec_pkg::WORD_W
) (
	input  wire logic                          ref_clk,
	input  wire logic                          rst,
	input  wire logic                          memory_mode_select,
	input  wire logic                          poll_input_n,
	input  wire logic [mdec_pkg::WORD_W-1:0]   data_in,
	output logic      [mdec_pkg::WORD_W-1:0]   data_out,
	output logic                               data_oe_n,
	output logic      [mdec_pkg::ADDR_W-1:0]   addr_out,
	output logic                               program_fetch_strobe_n,
	output logic                               read_data_strobe_n,
	output logic                               write_strobe_n,
	output logic                               quarter_clock_output,
	output logic                               poll_state,
	output logic                               int_enable,
	output logic                               saturation_mode,
	output logic      [mdec_pkg::WORD_W-1:0]   acc_out,
	output logic      [mdec_pkg::WORD_W-1:0]   product_out
);
	import mdec_pkg::*;

	// upper byte of an instruction against an eight-bit opcode
	function automatic logic op8_hit(
		input logic [15:0] w,
		input logic [7:0]  op
	);
		return w[15:8] == op;
	endfunction

	// whole instruction against a fixed sixteen-bit opcode
	function automatic logic word_hit(
		input logic [15:0] w,
		input logic [15:0] op
	);
		return w == op;
	endfunction

	// local memories
	logic [WORD-1:0]   prog_mem  [0:(1<<ADDR_W)-1];
	logic [WORD-1:0]   data_mem  [0:(1<<DADDR_W)-1];
	logic [WORD-1:0]   stack_mem [0:STACK_D-1];

	// sequencing state
	phase_t            phase_q;
	phase_t            phase_d;
	logic [ADDR_W-1:0] pc_q;
	logic [WORD-1:0]   ir_q;

	// arithmetic and status registers
	logic [31:0]       acc_q;
	logic [31:0]       prod_q;
	logic [WORD-1:0]   mult_q;
	logic [WORD-1:0]   status_q;
	logic [1:0]        stack_ptr_q;

	// pin registers
	logic [1:0]        div_q;
	logic [WORD-1:0]   data_out_q;
	logic              oe_n_q;
	logic              fetch_n_q;
	logic              rd_n_q;
	logic              wr_n_q;
	logic [ADDR_W-1:0] addr_q;
	logic              poll_q;

	// fetch source per memory mode
	// after reset the first external word is taken without a strobe
	wire logic            ext_prog = ~memory_mode_select;
	wire logic            in_fetch = phase_q == S_FETCH;
	wire logic            in_exec2 = phase_q == S_EXEC2;
	wire logic            in_exec3 = phase_q == S_EXEC3;
	wire logic [WORD-1:0] fetched  = ext_prog ? data_in : prog_mem[pc_q];
	wire logic [WORD-1:0] ir       = in_fetch ? fetched : ir_q;

	// field decode
	// fields only mean something in the phase that uses them
	wire logic [4:0]         op5      = ir[15:11];
	wire logic [2:0]         port_sel = ir[10:8];
	wire logic [DADDR_W-1:0] dma      = {1'b0, ir[6:0]};
	wire logic [DADDR_W-1:0] dma_up   = dma + 8'h01;
	wire logic [WORD-1:0]    dword    = data_mem[dma];
	wire logic [12:0]        imm13    = ir[12:0];

	// whole-word opcodes
	wire logic is_prod_to_acc = word_hit(ir, OP_PRODUCT_TO_ACC);
	wire logic is_add_prod    = word_hit(ir, OP_ADD_PRODUCT);
	wire logic is_sub_prod    = word_hit(ir, OP_SUBTRACT_PRODUCT);
	wire logic is_ints_on     = word_hit(ir, OP_INTERRUPTS_ON);
	wire logic is_ints_off    = word_hit(ir, OP_INTERRUPTS_OFF);
	wire logic is_sat_on      = word_hit(ir, OP_SATURATION_ON);
	wire logic is_sat_off     = word_hit(ir, OP_SATURATION_OFF);
	wire logic is_pop         = word_hit(ir, OP_POP);
	wire logic is_push        = word_hit(ir, OP_PUSH);

	// opcodes with a data address in the low byte
	wire logic is_load_mult   = op8_hit(ir, OP8_LOAD_MULTIPLICAND);
	wire logic is_load_add    = op8_hit(ir, OP8_LOAD_MULT_AND_ADD);
	wire logic is_load_move   = op8_hit(ir, OP8_LOAD_ADD_MOVE);
	wire logic is_mult_mem    = op8_hit(ir, OP8_MULTIPLY_BY_MEMORY);
	wire logic is_load_status = op8_hit(ir, OP8_LOAD_STATUS_WORD);
	wire logic is_store_stat  = op8_hit(ir, OP8_STORE_STATUS_WORD);
	wire logic is_shift_copy  = op8_hit(ir, OP8_DATA_SHIFT_COPY);
	wire logic is_tbl_read    = op8_hit(ir, OP8_PROG_TABLE_READ);
	wire logic is_tbl_write   = op8_hit(ir, OP8_PROG_TABLE_WRITE);

	// opcodes with a port or an immediate field
	wire logic is_port_in     = op5 == OP5_IN;
	wire logic is_port_out    = op5 == OP5_OUT;
	wire logic is_mult_const  = ir[15:13] == OP3_MULTIPLY_BY_CONSTANT;

	// number of cycles each instruction takes
	wire logic two_cyc   = is_pop | is_push |
		is_port_in | is_port_out;
	wire logic three_cyc = is_tbl_read | is_tbl_write;
	wire logic one_cyc   = !two_cyc && !three_cyc;
	wire logic last      = in_exec3 || (in_exec2 && two_cyc) ||
		(in_fetch && one_cyc);

	// arithmetic on accumulator and product
	// sign-extended immediate for the constant multiply
	wire logic [WORD-1:0]   mult_opnd =
		is_mult_const ? {{3{imm13[12]}}, imm13} : dword;
	wire logic [31:0]       mult_res  = $signed(mult_q) * $signed(mult_opnd);
	wire logic [31:0]       acc_plus  = acc_q + prod_q;
	wire logic [31:0]       acc_minus = acc_q - prod_q;
	wire logic [ADDR_W-1:0] tbl_addr  = acc_q[ADDR_W-1:0];
	wire logic [ADDR_W-1:0] pc_next   = pc_q + 12'h001;
	// stack pointer wraps; a fifth push overwrites the oldest entry
	wire logic [1:0]        sp_dn     = stack_ptr_q - 2'd1;
	wire logic [1:0]        sp_up     = stack_ptr_q + 2'd1;

	// accumulator and multiplicand selection
	// the stack keeps only the low word of the accumulator
	wire logic        acc_add   = is_add_prod | is_load_add | is_load_move;
	wire logic        load_mult = is_load_mult | is_load_add | is_load_move;
	wire logic        set_prod  = is_mult_mem | is_mult_const;
	wire logic [31:0] popped    = {16'h0000, stack_mem[sp_dn]};
	wire logic [31:0] acc_d     =
		(in_fetch && is_prod_to_acc) ? prod_q :
		(in_fetch && acc_add)        ? acc_plus :
		(in_fetch && is_sub_prod)    ? acc_minus :
		(in_exec2 && is_pop)         ? popped :
		acc_q;

	// phase sequencing
	always_comb begin
		phase_d = phase_q;
		unique case (phase_q)
			S_FETCH: phase_d = last ? S_FETCH : S_EXEC2;
			S_EXEC2: phase_d = last ? S_FETCH : S_EXEC3;
			S_EXEC3: phase_d = S_FETCH;
			default: phase_d = S_FETCH;
		endcase
	end

	// program counter advances once per instruction
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			phase_q <= S_FETCH;
			pc_q <= '0;
			ir_q <= '0;
		end else begin
			phase_q <= phase_d;
			if (in_fetch)
				ir_q <= fetched;
			if (last)
				pc_q <= pc_next;
		end
	end

	// accumulator, product, multiplicand
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			acc_q <= '0;
			prod_q <= '0;
			mult_q <= '0;
		end else begin
			acc_q <= acc_d;
			if (in_fetch && load_mult)
				mult_q <= dword;
			if (in_fetch && set_prod)
				prod_q <= mult_res;
		end
	end

	// status and stack
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			status_q <= ST_RESET;
			stack_ptr_q <= '0;
		end else if (in_fetch) begin
			if (is_load_status)
				status_q <= dword;
			else if (is_ints_on)
				status_q[ST_INTM] <= 1'b1;
			else if (is_ints_off)
				status_q[ST_INTM] <= 1'b0;
			else if (is_sat_on)
				status_q[ST_OVM] <= 1'b1;
			else if (is_sat_off)
				status_q[ST_OVM] <= 1'b0;
		end else if (in_exec2) begin
			if (is_push) begin
				stack_mem[stack_ptr_q] <= acc_q[15:0];
				stack_ptr_q <= sp_up;
			end else if (is_pop) begin
				stack_ptr_q <= sp_dn;
			end
		end
	end

	// data memory writes
	// port and table reads land at the end of their strobe cycle
	always_ff @(posedge ref_clk) begin
		if (!rst) begin
			if (in_fetch) begin
				if (is_store_stat)
					data_mem[dma] <= status_q;
				else if (is_shift_copy || is_load_move)
					data_mem[dma_up] <= dword;
			end else if (in_exec2 && is_port_in) begin
				data_mem[dma] <= data_in;
			end else if (in_exec3 && is_tbl_read) begin
				data_mem[dma] <= ext_prog ? data_in :
					prog_mem[tbl_addr];
			end
		end
	end

	// program memory writes
	// in external mode a table write only drives the bus
	always_ff @(posedge ref_clk) begin
		if (!rst && in_exec3 && is_tbl_write && !ext_prog)
			prog_mem[tbl_addr] <= dword;
	end

	// external bus strobes and address, registered for next cycle
	// registering them keeps each strobe clean for one whole cycle
	wire logic fetch_n_d = ~(last && ext_prog);
	wire logic rd_n_d    = ~(in_fetch && is_port_in ||
		in_exec2 && is_tbl_read && ext_prog);
	wire logic wr_n_d    = ~(in_fetch && is_port_out ||
		in_exec2 && is_tbl_write && ext_prog);
	// port select replaces the memory address for in and out
	wire logic [ADDR_W-1:0] addr_d =
		(in_fetch && (is_port_in || is_port_out)) ?
			{9'h000, port_sel} :
		(in_exec2 && three_cyc) ? tbl_addr :
		last ? pc_next : pc_q;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fetch_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			addr_q <= '0;
			data_out_q <= '0;
		end else begin
			fetch_n_q <= fetch_n_d;
			rd_n_q <= rd_n_d;
			wr_n_q <= wr_n_d;
			oe_n_q <= wr_n_d;
			addr_q <= addr_d;
			if (!wr_n_d)
				data_out_q <= dword;
		end
	end

	// quarter rate clock divider
	// free running, so the output keeps its phase across instructions
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			div_q <= '0;
			poll_q <= 1'b0;
		end else begin
			div_q <= div_q + 2'd1;
			poll_q <= ~poll_input_n;
		end
	end

	// clock and bus pins
	assign quarter_clock_output = div_q[1];
	assign program_fetch_strobe_n = fetch_n_q;
	assign read_data_strobe_n = rd_n_q;
	assign write_strobe_n = wr_n_q;
	assign data_oe_n = oe_n_q;
	assign data_out = data_out_q;
	assign addr_out = addr_q;

	// visible register state
	assign poll_state = poll_q;
	assign int_enable = status_q[ST_INTM];
	assign saturation_mode = status_q[ST_OVM];
	assign acc_out = acc_q[15:0];
	assign product_out = prod_q[15:0];
endmodule : mdec_core
`default_nettype wire

/* pkg/mdec_pkg.sv */
// constants and types for the multiply, control and i/o decoder
// Notes on behaviour
// - product_to_acc copies product into accumulator, one cycle, one word.
// - add_product adds product to accumulator in one cycle.
// - subtract_product subtracts product from accumulator in one cycle.
// - load_mult_and_add loads multiplicand and adds product, one cycle.
// - load-add-move also copies the data word one location higher.
// - multiply_by_memory puts multiplicand times data word into product.
// - multiply_by_constant uses the 13-bit immediate, one cycle.
// - load_status_word loads status from data memory, one cycle.
// - store_status_word writes status to data memory, one cycle.
// - stack pop moves top of stack into accumulator, two cycles.
// - stack push puts accumulator onto the stack, two cycles.
// - data_shift_copy copies the data word to the next higher address.
// - port input and output take two cycles, 3-bit port field.
// - prog_table_read copies program word into data RAM, three cycles.
// - prog_table_write copies data RAM word into program memory, three cycles
// - quarter_clock_output runs at a quarter of the input clock.
// - memory_mode_select high is internal program, low external program.
// - program_fetch_strobe asserted while external instruction is expected, except at the first fetch after reset.
// - read_data_strobe asserted while the peripheral drives input data.
// - write strobe asserted while the device drives output data.
// - port address sits on the three lowest address lines during i/o.
// - poll_input is an external input, active low, tested by software.
// - port field is decoded apart from address field and mode bit.
`default_nettype none
package mdec_pkg;
	localparam int WORD_W = 16;
	localparam int ADDR_W = 12;
	localparam int DADDR_W = 8;
	localparam int STACK_D = 4;
	localparam int CLK_DIV = 4;
	localparam logic [15:0] OP_PRODUCT_TO_ACC = 16'h7f8e;
	localparam logic [15:0] OP_ADD_PRODUCT = 16'h7f8f;
	localparam logic [15:0] OP_SUBTRACT_PRODUCT = 16'h7f90;
	localparam logic [15:0] OP_INTERRUPTS_OFF = 16'h7f81;
	localparam logic [15:0] OP_INTERRUPTS_ON = 16'h7f82;
	localparam logic [15:0] OP_NOP = 16'h7f80;
	localparam logic [15:0] OP_POP = 16'h7f9d;
	localparam logic [15:0] OP_PUSH = 16'h7f9c;
	localparam logic [15:0] OP_SATURATION_OFF = 16'h7f8a;
	localparam logic [15:0] OP_SATURATION_ON = 16'h7f8b;
	localparam logic [7:0] OP8_LOAD_MULTIPLICAND = 8'h6a;
	localparam logic [7:0] OP8_LOAD_MULT_AND_ADD = 8'h6c;
	localparam logic [7:0] OP8_LOAD_ADD_MOVE = 8'h6b;
	localparam logic [7:0] OP8_MULTIPLY_BY_MEMORY = 8'h6d;
	localparam logic [7:0] OP8_LOAD_STATUS_WORD = 8'h7b;
	localparam logic [7:0] OP8_STORE_STATUS_WORD = 8'h7c;
	localparam logic [7:0] OP8_DATA_SHIFT_COPY = 8'h69;
	localparam logic [7:0] OP8_PROG_TABLE_READ = 8'h67;
	localparam logic [7:0] OP8_PROG_TABLE_WRITE = 8'h7d;
	localparam logic [4:0] OP5_IN = 5'h08;
	localparam logic [4:0] OP5_OUT = 5'h09;
	localparam logic [2:0] OP3_MULTIPLY_BY_CONSTANT = 3'h4;
	localparam int ST_OVM = 0;
	localparam int ST_INTM = 1;
	localparam logic [15:0] ST_RESET = 16'h0000;
	typedef enum logic [2:0] {
		S_FETCH, S_EXEC2, S_EXEC3
	} phase_t;
endpackage : mdec_pkg
`default_nettype wire

/* verification/mdec_properties.sv */
// concurrent checks on the decoder top ports
`default_nettype none
module mdec_properties (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic memory_mode_select,
	input wire logic poll_input_n,
	input wire logic data_oe_n,
	input wire logic program_fetch_strobe_n,
	input wire logic read_data_strobe_n,
	input wire logic write_strobe_n,
	input wire logic quarter_clock_output,
	input wire logic poll_state,
	input wire logic int_enable,
	input wire logic saturation_mode
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	chk_clock_quarter: assert property (
		!$past(rst) && !$past(rst, 2) && !$past(rst, 3) |->
		quarter_clock_output != $past(quarter_clock_output, 2))
		else $error("quarter clock not at a quarter rate");
	chk_write_enable: assert property (data_oe_n == write_strobe_n)
		else $error("bus drive and write strobe disagree");
	chk_write_single: assert property (
		!write_strobe_n |=> write_strobe_n)
		else $error("write strobe longer than one cycle");
	chk_read_single: assert property (
		!read_data_strobe_n |=> read_data_strobe_n)
		else $error("read strobe longer than one cycle");
	chk_read_write: assert property (
		!read_data_strobe_n |-> write_strobe_n)
		else $error("read and write strobes together");
	chk_poll_lag: assert property (
		!$past(rst) |-> poll_state == !$past(poll_input_n))
		else $error("poll state does not follow poll input");
	chk_fetch_internal: assert property (
		memory_mode_select && $past(memory_mode_select) |->
		program_fetch_strobe_n)
		else $error("fetch strobe in internal program mode");
	chk_reset_quiet: assert property (disable iff (1'b0)
		rst |=> program_fetch_strobe_n && read_data_strobe_n &&
		write_strobe_n)
		else $error("strobe active after reset");
	chk_flags_clear: assert property (disable iff (1'b0)
		rst |=> !int_enable && !saturation_mode)
		else $error("mode flags set after reset");
endmodule // mdec_properties
bind mdec_core mdec_properties i_mdec_properties (
	.ref_clk(ref_clk), .rst(rst), .memory_mode_select(memory_mode_select),
	.poll_input_n(poll_input_n), .data_oe_n(data_oe_n),
	.program_fetch_strobe_n(program_fetch_strobe_n),
	.read_data_strobe_n(read_data_strobe_n),
	.write_strobe_n(write_strobe_n), .poll_state(poll_state),
	.quarter_clock_output(quarter_clock_output),
	.int_enable(int_enable), .saturation_mode(saturation_mode));
`default_nettype wire

/* verification/mdec_ext_mem.sv */
// external program memory and i/o port model
`default_nettype none
module mdec_ext_mem (
	input  wire logic                        ref_clk,
	input  wire logic                        rst,
	input  wire logic [mdec_pkg::ADDR_W-1:0] addr_out,
	input  wire logic                        program_fetch_strobe_n,
	input  wire logic                        read_data_strobe_n,
	output logic      [mdec_pkg::WORD_W-1:0] data_in
);
	import mdec_pkg::*;
	logic [WORD_W-1:0] prog [64];
	logic [WORD_W-1:0] port_val [8];
	logic              first_q;
	logic [WORD_W-1:0] last_q;
	always_ff @(posedge ref_clk) begin
		first_q <= rst;
		last_q <= data_in;
	end
	// released bus shows a changing pattern
	assign data_in = (!program_fetch_strobe_n || first_q) ?
		prog[addr_out[5:0]] :
		!read_data_strobe_n ? port_val[addr_out[2:0]] : ~last_q;
endmodule // mdec_ext_mem
`default_nettype wire

/* verification/mdec_core_test.sv */
// self-checking bench for the decoder
`default_nettype none
module mdec_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	import mdec_pkg::*;
	typedef struct packed {logic [2:0] port; logic [15:0] val;} wr_t;
	logic              ref_clk = 0, rst = 1, mode = 0, poll_n = 1;
	logic [WORD_W-1:0] data_in, data_out, acc_out, product_out;
	logic [ADDR_W-1:0] addr_out;
	logic              oe_n, fetch_n, rd_n, wr_n, qclk, poll_st, ie, sat;
	int                err_count = 0, comparisons = 0, cycles = 0;
	wr_t               exp_q [$];
	mdec_core i_mdec_core (.ref_clk(ref_clk), .rst(rst),
		.memory_mode_select(mode), .poll_input_n(poll_n),
		.data_in(data_in), .data_out(data_out), .data_oe_n(oe_n),
		.addr_out(addr_out), .program_fetch_strobe_n(fetch_n),
		.read_data_strobe_n(rd_n), .write_strobe_n(wr_n),
		.quarter_clock_output(qclk), .poll_state(poll_st),
		.int_enable(ie), .saturation_mode(sat), .acc_out(acc_out),
		.product_out(product_out));
	mdec_ext_mem i_mdec_ext_mem (.ref_clk(ref_clk), .rst(rst),
		.addr_out(addr_out), .program_fetch_strobe_n(fetch_n),
		.read_data_strobe_n(rd_n), .data_in(data_in));
	task automatic check(string what, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (e !== g) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", what, e, g);
		end
	endtask
	task automatic final_report();
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	function automatic logic [15:0] m_op(logic [7:0] op, int d);
		return {op, 1'b0, d[6:0]};
	endfunction
	function automatic logic [15:0] io_op(logic [4:0] op, int p, int d);
		return {op, p[2:0], 1'b0, d[6:0]};
	endfunction
	initial forever #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 400) begin
			err_count++;
			final_report();
		end
	end
	// peripheral side takes each output word
	always @(negedge ref_clk) if (!rst && wr_n === 1'b0) begin
		wr_t e;
		e = exp_q.size() ? exp_q.pop_front() : 'x;
		check("out port", e.port, addr_out[2:0]);
		check("out data", e.val, data_out);
	end
	initial begin
		logic [15:0] w [20];
		logic [15:0] v;
		logic [31:0] k, pk, pv;
		void'($urandom(21));
		v = 16'($urandom_range(1, 127));
		k = $urandom_range(1, 4095);
		pk = v * k;
		pv = v * v;
		w = '{OP_NOP, OP_SATURATION_ON, OP_INTERRUPTS_ON,
			io_op(OP5_IN, 3, 5), m_op(OP8_LOAD_MULTIPLICAND, 5),
			{OP3_MULTIPLY_BY_CONSTANT, k[12:0]}, OP_PRODUCT_TO_ACC,
			io_op(OP5_OUT, 6, 5), m_op(OP8_STORE_STATUS_WORD, 6),
			io_op(OP5_OUT, 7, 6), m_op(OP8_MULTIPLY_BY_MEMORY, 5),
			OP_ADD_PRODUCT, m_op(OP8_DATA_SHIFT_COPY, 5),
			io_op(OP5_OUT, 0, 6), OP_INTERRUPTS_OFF, OP_SATURATION_OFF,
			OP_SUBTRACT_PRODUCT, OP_PUSH, OP_PRODUCT_TO_ACC, OP_POP};
		foreach (i_mdec_ext_mem.prog[i]) i_mdec_ext_mem.prog[i] = OP_NOP;
		foreach (w[i]) i_mdec_ext_mem.prog[i] = w[i];
		i_mdec_ext_mem.port_val[3] = v;
		exp_q = '{{3'h6, v}, {3'h7, 16'h0003}, {3'h0, v}};
		repeat (3) @(negedge ref_clk);
		rst = 0;
		repeat (60) begin
			@(negedge ref_clk);
			poll_n = 1'($urandom);
		end
		check("acc", pk[15:0], acc_out);
		check("product", pv[15:0], product_out);
		check("flags", 0, {ie, sat});
		check("writes left", 0, exp_q.size());
		rst = 1;
		mode = 1;
		repeat (3) @(negedge ref_clk);
		rst = 0;
		repeat (10) @(negedge ref_clk);
		final_report();
	end
endmodule // mdec_core_test
`default_nettype wire
